// ===== src/fsk_pkg.sv
// Shared constants for the FSK modem core: clock rates, tone periods, thresholds, widths
package fsk_pkg;

   // System clock and the 1 MHz reference derived from it
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned REF_HZ = 1_000_000;
   localparam logic [4:0] REF_DIV = 5'(CLK_HZ / REF_HZ);

   // Nominal tone frequencies in Hz
   localparam int unsigned LOW_SPACE_HZ = 1070;
   localparam int unsigned LOW_MARK_HZ = 1270;
   localparam int unsigned HIGH_SPACE_HZ = 2025;
   localparam int unsigned HIGH_MARK_HZ = 2225;

   // Tone period in reference ticks, rounded to nearest for least frequency error
   localparam int unsigned PER_W = 10;
   localparam logic [9:0] LOW_SPACE_PER = 10'((REF_HZ + LOW_SPACE_HZ / 2) / LOW_SPACE_HZ);
   localparam logic [9:0] LOW_MARK_PER = 10'((REF_HZ + LOW_MARK_HZ / 2) / LOW_MARK_HZ);
   localparam logic [9:0] HIGH_SPACE_PER = 10'((REF_HZ + HIGH_SPACE_HZ / 2) / HIGH_SPACE_HZ);
   localparam logic [9:0] HIGH_MARK_PER = 10'((REF_HZ + HIGH_MARK_HZ / 2) / HIGH_MARK_HZ);

   // Sixteen phase steps per tone cycle, eight output levels
   localparam logic [10:0] STEP_INC = 11'h010;
   localparam int unsigned LEVEL_W = 3;

   // Half-cycle discrimination thresholds
   localparam int unsigned LOW_HALF_THR_US = 429;
   localparam int unsigned HIGH_HALF_THR_NS =
      (500_000_000 / HIGH_SPACE_HZ + 500_000_000 / HIGH_MARK_HZ) / 2;
   localparam int unsigned HALF_W = 15;
   localparam logic [14:0] LOW_HALF_THR = 15'(LOW_HALF_THR_US * (REF_HZ / 1_000_000));
   localparam logic [14:0] HIGH_HALF_THR = 15'(HIGH_HALF_THR_NS / (1_000_000_000 / REF_HZ));
   localparam logic [14:0] HALF_MAX = 15'h7FFF;

   // Receive result word: {mark, half-cycle length}
   localparam int unsigned WORD_W = 16;
   localparam int unsigned FIFO_DEPTH = 4;

   // Stepped sine, levels weighted toward the fundamental by dwelling at the peaks
   function automatic logic [2:0] fsk_sine_level(input logic [3:0] phase);
      logic [2:0] lvl;
      lvl = 3'h0;
      case (phase)
         4'h0: lvl = 3'h4;
         4'h1: lvl = 3'h5;
         4'h2: lvl = 3'h6;
         4'h3: lvl = 3'h7;
         4'h4: lvl = 3'h7;
         4'h5: lvl = 3'h6;
         4'h6: lvl = 3'h5;
         4'h7: lvl = 3'h4;
         4'h8: lvl = 3'h3;
         4'h9: lvl = 3'h2;
         4'hA: lvl = 3'h1;
         4'hB: lvl = 3'h0;
         4'hC: lvl = 3'h0;
         4'hD: lvl = 3'h1;
         4'hE: lvl = 3'h2;
         4'hF: lvl = 3'h3;
         default: lvl = 3'h4;
      endcase
      return lvl;
   endfunction

endpackage

// ===== src/fsk_stream_if.sv
// Valid/ready word stream between the modem core and its receive FIFO
`timescale 1ns/100ps
`default_nettype none
interface fsk_stream_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== src/fsk_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module fsk_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Streams
   fsk_stream_if.snk wr,
   fsk_stream_if.src rd
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [CW-1:0] count;
   } fsk_fifo_state_type;

   fsk_fifo_state_type s_q;
   fsk_fifo_state_type s_d;
   logic wr_ok;
   logic rd_ok;

   assign wr.ready = (s_q.count != CW'(DEPTH));
   assign rd.valid = (s_q.count != '0);
   assign rd.data = s_q.mem[s_q.rptr];

   always_comb begin
      s_d = s_q;
      wr_ok = wr.valid && (s_q.count != CW'(DEPTH));
      rd_ok = rd.ready && (s_q.count != '0);
      if (wr_ok) begin
         s_d.mem[s_q.wptr] = wr.data;
         s_d.wptr = (s_q.wptr == PW'(DEPTH - 1)) ? '0 : s_q.wptr + 1'b1;
      end
      if (rd_ok) begin
         s_d.rptr = (s_q.rptr == PW'(DEPTH - 1)) ? '0 : s_q.rptr + 1'b1;
      end
      if (wr_ok && !rd_ok) begin
         s_d.count = s_q.count + 1'b1;
      end else if (rd_ok && !wr_ok) begin
         s_d.count = s_q.count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule
`default_nettype wire

// ===== src/fsk_modem_core.sv
// Digital FSK modem core: tone synthesiser, stepped sine, half-cycle demodulator
`timescale 1ns/100ps
`default_nettype none
module fsk_modem_core (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Terminal side
   input wire logic orig_mode,
   input wire logic tx_bit,
   output logic rx_data,
   output logic rx_word_valid,
   output logic [15:0] rx_word,
   input wire logic rx_word_ready,
   output logic rx_overrun,
   // Line front end
   input wire logic line_sq,
   output logic [2:0] tx_level
);

   typedef struct packed {
      logic [4:0] ref_cnt;
      logic ref_tick;
      logic [9:0] acc;
      logic [3:0] phase;
      logic [2:0] level;
      logic line_prev;
      logic [14:0] half_cnt;
      logic rx_bit;
      logic pend_valid;
      logic [15:0] pend_word;
      logic overrun;
      logic out_valid;
      logic [15:0] out_word;
   } fsk_core_state_type;

   fsk_core_state_type s_q;
   fsk_core_state_type s_d;

   fsk_stream_if #(.W(fsk_pkg::WORD_W)) fifo_in ();
   fsk_stream_if #(.W(fsk_pkg::WORD_W)) fifo_out ();

   fsk_fifo #(
      .W(fsk_pkg::WORD_W),
      .DEPTH(fsk_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .clk(mclk),
      .rst_n(reset_n),
      .wr(fifo_in),
      .rd(fifo_out)
   );

   logic [9:0] tone_per;
   logic [14:0] half_thr;
   logic [10:0] acc_next;
   logic edge_seen;
   logic is_mark;

   // Pending result is held until the FIFO takes it or a newer measurement replaces it
   assign fifo_in.valid = s_q.pend_valid;
   assign fifo_in.data = s_q.pend_word;
   assign fifo_out.ready = !s_q.out_valid || rx_word_ready;

   always_comb begin
      s_d = s_q;
      // Transmit band from mode, tone from data bit; mark is the higher tone
      if (orig_mode) begin
         tone_per = tx_bit ? fsk_pkg::LOW_MARK_PER : fsk_pkg::LOW_SPACE_PER;
      end else begin
         tone_per = tx_bit ? fsk_pkg::HIGH_MARK_PER : fsk_pkg::HIGH_SPACE_PER;
      end
      // Receive band is the opposite one
      half_thr = orig_mode ? fsk_pkg::HIGH_HALF_THR : fsk_pkg::LOW_HALF_THR;
      acc_next = {1'b0, s_q.acc} + fsk_pkg::STEP_INC;
      edge_seen = (line_sq != s_q.line_prev);
      is_mark = (s_q.half_cnt < half_thr);

      // 1 MHz reference as a one-cycle enable
      if (s_q.ref_cnt == fsk_pkg::REF_DIV - 5'h01) begin
         s_d.ref_cnt = 5'h00;
         s_d.ref_tick = 1'b1;
      end else begin
         s_d.ref_cnt = s_q.ref_cnt + 5'h01;
         s_d.ref_tick = 1'b0;
      end

      // Bresenham stepping: sixteen steps spread over exactly tone_per reference ticks,
      // so the cycle length is an exact integer and the rounding error stays below 0.1%
      if (s_q.ref_tick) begin
         if (acc_next >= {1'b0, tone_per}) begin
            s_d.acc = 10'(acc_next - {1'b0, tone_per});
            s_d.phase = s_q.phase + 4'h1;
         end else begin
            s_d.acc = acc_next[9:0];
         end
      end
      // A mode or data change mid-cycle leaves a residue at or above the new period; clear it to zero
      if (s_d.acc >= tone_per) begin
         s_d.acc = 10'h000;
      end
      s_d.level = fsk_pkg::fsk_sine_level(s_q.phase);

      // Half-cycle timing on reference ticks, saturating on a dead line
      s_d.line_prev = line_sq;
      if (edge_seen) begin
         s_d.half_cnt = 15'h0000;
         s_d.rx_bit = is_mark;
      end else if (s_q.ref_tick && (s_q.half_cnt != fsk_pkg::HALF_MAX)) begin
         s_d.half_cnt = s_q.half_cnt + 15'h0001;
      end

      // Handing results to the FIFO; a full FIFO stalls the pending slot
      if (s_q.pend_valid && fifo_in.ready) begin
         s_d.pend_valid = 1'b0;
      end
      if (edge_seen) begin
         if (s_q.pend_valid && !fifo_in.ready) begin
            // Newest measurement replaces the stalled one; software sees the loss
            s_d.overrun = 1'b1;
         end
         s_d.pend_valid = 1'b1;
         s_d.pend_word = {is_mark, s_q.half_cnt};
      end

      // Registered output stage so the terminal port comes from flip-flops
      if (fifo_out.valid && fifo_out.ready) begin
         s_d.out_valid = 1'b1;
         s_d.out_word = fifo_out.data;
      end else if (rx_word_ready) begin
         s_d.out_valid = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rx_data = s_q.rx_bit;
   assign rx_word_valid = s_q.out_valid;
   assign rx_word = s_q.out_word;
   assign rx_overrun = s_q.overrun;
   assign tx_level = s_q.level;

endmodule
`default_nettype wire

// ===== tb/fsk_core_monitor.sv
// Port checker for the FSK modem core
`timescale 1ns/100ps
`default_nettype none
module fsk_core_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Terminal side
   input wire logic orig_mode,
   input wire logic tx_bit,
   input wire logic rx_data,
   input wire logic rx_word_valid,
   input wire logic [15:0] rx_word,
   input wire logic rx_word_ready,
   input wire logic rx_overrun,
   // Line side
   input wire logic line_sq,
   input wire logic [2:0] tx_level
);
   logic [15:0] gap_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Peak and trough levels repeat over two steps: slowest tone needs up to 117 ticks there
   always_ff @(posedge mclk) begin
      gap_q <= (!reset_n || $changed(tx_level)) ? 16'h0000 : gap_q + 16'h0001;
   end
   sequence s_edge;
      $past(reset_n) && line_sq != $past(line_sq);
   endsequence
   sequence s_fresh;
      s_edge ##1 !rx_word_valid ##[1:2] $rose(rx_word_valid);
   endsequence
   a_rx_on_edge: assert property ($changed(rx_data) && $past(reset_n, 2)
      |-> $past(line_sq) != $past(line_sq, 2)) else $error("rx_data off edge");
   a_sine_step: assert property ($changed(tx_level) && $past(reset_n, 2)
      |-> 3'(tx_level - $past(tx_level)) inside {3'h1, 3'h7} ##1 $stable(tx_level) [*8])
      else $error("bad sine step");
   a_tone_alive: assert property (gap_q < 16'h0960) else $error("sine stalled");
   a_word_mark: assert property (rx_word_valid |-> rx_word[15] == (rx_word[14:0] <
      (orig_mode ? fsk_pkg::HIGH_HALF_THR : fsk_pkg::LOW_HALF_THR))) else $error("bad slice");
   a_word_soon: assert property (s_edge ##1 !rx_word_valid |-> ##[1:2] rx_word_valid)
      else $error("word late");
   a_word_fresh: assert property (s_fresh |-> rx_word[15] == rx_data)
      else $error("word not rx_data");
   a_word_hold: assert property (rx_word_valid && !rx_word_ready
      |=> rx_word_valid && $stable(rx_word)) else $error("word dropped");
   a_overrun_stick: assert property (rx_overrun |=> rx_overrun) else $error("overrun cleared");
endmodule
bind fsk_modem_core fsk_core_monitor i_mon (.mclk, .reset_n, .orig_mode, .tx_bit, .rx_data,
   .rx_word_valid, .rx_word, .rx_word_ready, .rx_overrun, .line_sq, .tx_level);
`default_nettype wire

// ===== tb/fsk_line_model.sv
// Line front end model: limiter square wave of settable half-cycle
`timescale 1ns/100ps
`default_nettype none
module fsk_line_model (
   // Clock
   input wire logic mclk,
   // Bench control
   input wire logic en,
   input wire logic [15:0] half_us,
   // Limiter output
   output logic line_sq
);
   logic [19:0] cnt_q = 20'h00000;
   initial line_sq = 1'b0;
   // Limiter keeps driving its last level while the carrier is off
   always @(negedge mclk) begin
      if (en && cnt_q + 20'h00001 >= 20'(half_us) * 20'h00014) begin
         line_sq <= !line_sq;
         cnt_q <= 20'h00000;
      end else if (en) begin
         cnt_q <= cnt_q + 20'h00001;
      end
   end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Bench for the FSK modem core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic mclk, reset_n, orig_mode, tx_bit, rx_data, rx_word_valid, rx_word_ready;
   logic rx_overrun, line_sq, en, stall;
   logic [15:0] rx_word, half_us;
   logic [2:0] tx_level;
   int fails, n_compared;
   fsk_modem_core i_dut (.mclk, .reset_n, .orig_mode, .tx_bit, .rx_data, .rx_word_valid,
      .rx_word, .rx_word_ready, .rx_overrun, .line_sq, .tx_level);
   fsk_line_model i_line (.mclk, .en, .half_us, .line_sq);
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(negedge mclk) rx_word_ready <= !stall && $urandom % 4 != 0;
   task automatic chk(input string what, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task automatic wait_tog;
      logic last;
      int i;
      last = line_sq;
      for (i = 0; i < 30000 && line_sq === last; i++) tick(1);
      if (i == 30000) begin
         fails++;
         test_done();
      end
   endtask
   // Cycles to the next wrap of the stepped sine from level 3 to 4
   task automatic wait_wrap(output int n);
      logic [2:0] prev;
      for (n = 1; n < 40000; n++) begin
         prev = tx_level;
         tick(1);
         if (prev === 3'h3 && tx_level === 3'h4) break;
      end
      if (n == 40000) begin
         fails++;
         test_done();
      end
   endtask
   // First wrap lets the tone settle, the second spans one whole cycle
   task automatic tone(input logic b, input int hz);
      int n;
      tx_bit = b;
      wait_wrap(n);
      wait_wrap(n);
      n = n * hz - 20000000;
      chk("tone", 16'(n < 20000 && n > -20000), 16'h0001);
   endtask
   task automatic drain;
      en = 1'b0;
      tick(40);
      chk("drained", 16'(rx_word_valid), 16'h0000);
   endtask
   // Corners sit two ticks below and one tick above the threshold, past the one-tick count error
   task automatic rx_run(input int thr, input int cnt);
      int h;
      en = 1'b1;
      for (int k = 0; k < cnt; k++) begin
         h = k == 1 ? thr - 2 : k == 2 ? thr + 1 : thr - 40 + int'($urandom % 80);
         h = (h == thr - 1 || h == thr) ? thr + 2 : h;
         half_us = 16'(h);
         wait_tog();
         tick(1);
         if (k > 0) chk("rx_data", 16'(rx_data), 16'(h < thr));
         tick(1);
         // Word reaches the empty output stage three edges after the line edge; length h or h-1
         if (k > 0) chk("rx_word", 16'(rx_word_valid && rx_word[15] == (h < thr) &&
            (rx_word[14:0] == 15'(h) || rx_word[14:0] == 15'(h - 1))), 16'h0001);
      end
      drain();
   endtask
   initial begin
      void'($urandom(90));
      {reset_n, orig_mode, tx_bit, en, stall} = 5'h00;
      half_us = 16'h00C8;
      fails = 0;
      n_compared = 0;
      tick(4);
      reset_n = 1'b1;
      for (int m = 1; m >= 0; m--) begin
         orig_mode = 1'(m);
         fork
            begin
               tone(1'b0, m ? 1070 : 2025);
               tone(1'b1, m ? 1270 : 2225);
            end
            rx_run(m ? 235 : 429, m ? 6 : 5);
         join
         $display("mode %0d done", m);
      end
      // Six words fit in the receive path, the seventh replaces the sixth
      {half_us, stall, en} = 18'h00053;
      repeat (6) wait_tog();
      tick(4);
      chk("overrun", 16'(rx_overrun), 16'h0000);
      wait_tog();
      tick(4);
      chk("overrun", 16'(rx_overrun), 16'h0001);
      $display("overrun done");
      {reset_n, stall} = 2'h0;
      tick(4);
      chk("reset", {12'h000, rx_overrun, tx_level}, 16'h0000);
      $display("reset done");
      test_done();
   end
endmodule
`default_nettype wire
